/* hw/dcc_pkg.sv */
// constants and types for the dual comparator control block
package dcc_pkg;

	// ----------------------------------------------------------------
	// register map, byte addresses
	// ----------------------------------------------------------------
	localparam logic [7:0] DCC_CTRL_ADDR   = 8'h9C;
	localparam logic [7:0] DCC_STATUS_ADDR = 8'hA0;
	localparam logic [7:0] DCC_MASK_ADDR   = 8'hA4;

	// ----------------------------------------------------------------
	// comparator_control fields
	// ----------------------------------------------------------------
	localparam int         DCC_CMP2_RESULT_BIT = 7;
	localparam int         DCC_CMP1_RESULT_BIT = 6;
	localparam int         DCC_CMP2_INVERT_BIT = 5;
	localparam int         DCC_CMP1_INVERT_BIT = 4;
	localparam int         DCC_INPUT_SWITCH_BIT = 3;
	localparam int         DCC_MODE_LSB        = 0;
	localparam logic [7:0] DCC_CTRL_WR_MASK    = 8'h3F;
	localparam logic [7:0] DCC_CTRL_RESET      = 8'h07;

	// ----------------------------------------------------------------
	// modes
	// ----------------------------------------------------------------
	localparam logic [2:0] DCC_MODE_SWITCH  = 3'h1;
	localparam logic [2:0] DCC_MODE_VREF    = 3'h2;
	localparam logic [2:0] DCC_MODE_OUTPUTS = 3'h6;
	localparam logic [2:0] DCC_MODE_OFF     = 3'h7;

	// ----------------------------------------------------------------
	// status and mask
	// ----------------------------------------------------------------
	localparam int         DCC_CHANGE_BIT    = 0;
	localparam logic [7:0] DCC_STATUS_RESET  = 8'h00;
	localparam logic [7:0] DCC_MASK_RESET    = 8'h00;
	localparam logic [7:0] DCC_EVENT_MASK    = 8'h01;

	// analog multiplexer steering toward the comparators and pins
	typedef struct packed {
		logic cmp1_enable;  // comparator 1 powered
		logic cmp2_enable;  // comparator 2 powered
		logic cmp1_neg_pin3; // 1: port_a_bit3, 0: port_a_bit0
		logic cmp2_neg_pin2; // 1: port_a_bit2, 0: port_a_bit1
		logic vref_to_pos;   // reference on both positive inputs
		logic out_route;     // results driven on port_a_bit3/4
	} dcc_route_t;

	localparam dcc_route_t DCC_ROUTE_RESET = 6'h00;

endpackage : dcc_pkg

/* hw/dcc_top.sv */
// dual comparator control: APB registers, result sync, change flag
// Notes on behaviour
// [RL1] two comparators on port A pins 0-3, results out on pins 3 and 4
// [RL2] internal voltage reference can feed the comparators besides the pins
// [RL3] control register steers input muxes and output muxes to the pins
// [RL4] 8-bit control at 9Ch; result bits read-only, others read/write
// [RL5] bit 7 is comparator 2, bit 6 comparator 1: high when plus above minus
// [RL6] bits 5 and 4 invert the reported results of comparators 2 and 1
// [RL7] modes 001, 010: switch bit picks pin 3 or pin 0 as comparator 1 minus
// [RL8] mode 010 with switch set puts pin 2 on comparator 2 minus
// [RL9] reset returns control register to off configuration, mode 111
// [RL10] change flag sets when either result differs from latched value
// [RL11] any control access ends mismatch; mismatch keeps setting the flag
// [RL12] mode 010 applies the reference to both positive inputs
// [RL13] raw comparator outputs pass a two-stage synchroniser before use
//
// Design decision made here: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module dcc_top
	import dcc_pkg::*;
(
	input  wire logic        pclk,            // 200 MHz bus clock
	input  wire logic        presetn,         // async reset, active low
	input  wire logic        psel,            // apb select
	input  wire logic        penable,         // apb access phase
	input  wire logic        pwrite,          // apb direction
	input  wire logic [7:0]  paddr,           // apb byte address
	input  wire logic [31:0] pwdata,          // apb write data
	output logic      [31:0] prdata,          // apb read data
	output logic             pready,          // apb ready
	output logic             pslverr,         // apb error
	input  wire logic        cmp1_raw,        // analog comparator 1 out
	input  wire logic        cmp2_raw,        // analog comparator 2 out
	output dcc_route_t       route,           // analog mux steering
	output logic             port_a_bit3_out, // comparator 1 result pin
	output logic             port_a_bit3_oe,  // drive enable, bit 3
	output logic             port_a_bit4_out, // comparator 2 result pin
	output logic             port_a_bit4_oe,  // drive enable, bit 4
	output logic             irq              // level interrupt
);

	// ----------------------------------------------------------------
	// functions
	// ----------------------------------------------------------------
	function automatic dcc_route_t route_of(input logic [7:0] ctrl);
		dcc_route_t r;
		logic [2:0] m;
		m = ctrl[DCC_MODE_LSB +: 3];
		r.cmp1_enable   = (m != DCC_MODE_OFF);                     // RL1
		r.cmp2_enable   = (m != DCC_MODE_OFF);                     // RL1
		r.cmp1_neg_pin3 = ctrl[DCC_INPUT_SWITCH_BIT]
			&& (m == DCC_MODE_SWITCH || m == DCC_MODE_VREF);       // RL7
		r.cmp2_neg_pin2 = ctrl[DCC_INPUT_SWITCH_BIT]
			&& (m == DCC_MODE_VREF);                               // RL8
		r.vref_to_pos   = (m == DCC_MODE_VREF);                    // RL2 RL12
		r.out_route     = (m == DCC_MODE_OUTPUTS);                 // RL1
		return r;
	endfunction : route_of

	function automatic logic is_access(input logic sel, input logic en);
		return sel && en;
	endfunction : is_access

	// ----------------------------------------------------------------
	// registers and nets
	// ----------------------------------------------------------------
	logic [7:0]  ctrl_r;
	logic [7:0]  status_r;
	logic [7:0]  mask_r;
	logic [7:0]  rd_status_r;
	logic [1:0]  sync1_r;
	logic [1:0]  sync2_r;
	logic [1:0]  result_r;
	logic [1:0]  latched_r;
	logic [31:0] prdata_r;
	logic        slverr_r;
	logic        setup;
	logic        done;
	logic        hit_ctrl;
	logic        hit_status;
	logic        hit_mask;
	logic        mapped;
	logic        mismatch;
	logic [7:0]  events;
	logic [1:0]  result_nxt;
	dcc_route_t  route_nxt;

	assign setup      = psel && !penable;
	assign done       = is_access(psel, penable);
	assign hit_ctrl   = (paddr == DCC_CTRL_ADDR);
	assign hit_status = (paddr == DCC_STATUS_ADDR);
	assign hit_mask   = (paddr == DCC_MASK_ADDR);
	assign mapped     = hit_ctrl || hit_status || hit_mask;
	// one decode feeds the steering flops and the checks
	assign route_nxt  = route_of(ctrl_r);

	// ----------------------------------------------------------------
	// apb slave
	// ----------------------------------------------------------------
	// one wait-free access phase; read data is built in setup so that
	// prdata comes from a flop
	assign pready  = done;
	assign pslverr = done && slverr_r;
	assign prdata  = prdata_r;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata_r    <= 32'h0000_0000;
			slverr_r    <= 1'b0;
			rd_status_r <= 8'h00;
		end
		else if (setup)
		begin
			slverr_r    <= !mapped;
			rd_status_r <= (hit_status && !pwrite) ? status_r : 8'h00;
			if (pwrite || !mapped)
				prdata_r <= 32'h0000_0000;
			else if (hit_ctrl)
				prdata_r <= {24'h00_0000, ctrl_r};                  // RL4
			else if (hit_status)
				prdata_r <= {24'h00_0000, status_r};
			else
				prdata_r <= {24'h00_0000, mask_r};
		end
	end

	// ----------------------------------------------------------------
	// control register
	// ----------------------------------------------------------------
	assign result_nxt = {sync2_r[1] & route.cmp2_enable,
		sync2_r[0] & route.cmp1_enable}
		^ {ctrl_r[DCC_CMP2_INVERT_BIT], ctrl_r[DCC_CMP1_INVERT_BIT]}; // RL6

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			ctrl_r <= DCC_CTRL_RESET;                                // RL9
		else if (done && pwrite && hit_ctrl)
			ctrl_r <= {result_nxt,                                   // RL5
				pwdata[5:0] & DCC_CTRL_WR_MASK[5:0]};                // RL4
		else
			ctrl_r[7:6] <= result_nxt;                               // RL5
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			result_r <= 2'b00;
		else
			result_r <= result_nxt;                                  // RL5
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			mask_r <= DCC_MASK_RESET;
		else if (done && pwrite && hit_mask)
			mask_r <= pwdata[7:0] & DCC_EVENT_MASK;
	end

	// ----------------------------------------------------------------
	// synchroniser
	// ----------------------------------------------------------------
	// comparator outputs are asynchronous to pclk
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sync1_r <= 2'b00;
			sync2_r <= 2'b00;
		end
		else
		begin
			sync1_r <= {cmp2_raw, cmp1_raw};                         // RL13
			sync2_r <= sync1_r;                                      // RL13
		end
	end

	// ----------------------------------------------------------------
	// change detection
	// ----------------------------------------------------------------
	// any completed control access refreshes the reference value
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			latched_r <= 2'b00;
		else if (done && hit_ctrl)
			latched_r <= result_r;                                   // RL11
	end

	assign mismatch = (result_r != latched_r);                       // RL10
	assign events   = {7'h00, mismatch};

	// read clears only what was seen; a new event wins over the clear
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			status_r <= DCC_STATUS_RESET;
		else if (done && hit_status && !pwrite)
			status_r <= (status_r & ~rd_status_r) | events;         // RL11
		else
			status_r <= status_r | events;                           // RL10
	end

	assign irq = |(status_r & mask_r);

	// ----------------------------------------------------------------
	// analog steering and result pins
	// ----------------------------------------------------------------
	// pins carry the synchronised result, four cycles behind the analog
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			route           <= DCC_ROUTE_RESET;
			port_a_bit3_out <= 1'b0;
			port_a_bit4_out <= 1'b0;
			port_a_bit3_oe  <= 1'b0;
			port_a_bit4_oe  <= 1'b0;
		end
		else
		begin
			route           <= route_nxt;                            // RL3
			port_a_bit3_out <= result_r[0];                          // RL1
			port_a_bit4_out <= result_r[1];                          // RL1
			port_a_bit3_oe  <= route_nxt.out_route;                  // RL3
			port_a_bit4_oe  <= route_nxt.out_route;                  // RL3
		end
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	a_ctrl_write_lands: assert property ( // RL4
		done && pwrite && hit_ctrl |=>
			ctrl_r[5:0] == $past(pwdata[5:0]))
		else $error("control write not stored");

	a_result_ro: assert property ( // RL4
		done && pwrite && hit_ctrl |=>
			ctrl_r[7:6] == $past(result_nxt))
		else $error("result bits were written");

	a_result_sync: assert property ( // RL5
		$stable(ctrl_r[5:0]) && route.cmp1_enable
			&& route_nxt.cmp1_enable && ctrl_r[4] == 1'b0
			##0 $stable(cmp1_raw)[*3] |=> result_r[0] == $past(cmp1_raw))
		else $error("comparator 1 result does not follow input");

	a_invert_flip: assert property ( // RL6
		ctrl_r[DCC_CMP1_INVERT_BIT] && route.cmp1_enable |->
			result_nxt[0] == !sync2_r[0])
		else $error("invert bit not applied");

	a_sync_depth: assert property ( // RL13
		sync2_r == $past(sync1_r) && sync1_r == $past({cmp2_raw, cmp1_raw}))
		else $error("synchroniser not two stages");

	a_mode_switch: assert property ( // RL7
		ctrl_r[2:0] == DCC_MODE_SWITCH && $stable(ctrl_r[3:0]) |=>
			route.cmp1_neg_pin3 == $past(ctrl_r[DCC_INPUT_SWITCH_BIT])
			&& !route.cmp2_neg_pin2 && !route.vref_to_pos)
		else $error("mode 001 steering wrong");

	a_mode_vref: assert property ( // RL8
		ctrl_r[3:0] == {1'b1, DCC_MODE_VREF} && $stable(ctrl_r[3:0]) |=>
			route.cmp2_neg_pin2 && route.cmp1_neg_pin3
			&& route.vref_to_pos)                                      // RL12
		else $error("mode 010 steering wrong");

	a_off_quiet: assert property ( // RL9
		ctrl_r[2:0] == DCC_MODE_OFF && $stable(ctrl_r[2:0]) |=>
			!route.cmp1_enable && !route.cmp2_enable
			&& !port_a_bit3_oe && !port_a_bit4_oe)
		else $error("off mode leaves comparators on");

	a_change_sets: assert property ( // RL10
		mismatch |=> status_r[DCC_CHANGE_BIT])
		else $error("change flag missed");

	a_mismatch_holds: assert property ( // RL11
		mismatch && !(done && hit_ctrl) ##1 $stable(result_r) |-> mismatch)
		else $error("mismatch ended without access");

	a_access_ends: assert property ( // RL11
		done && hit_ctrl ##1 $stable(result_r) |-> !mismatch)
		else $error("control access did not end mismatch");

	a_irq_level: assert property (
		status_r[DCC_CHANGE_BIT] && mask_r[DCC_CHANGE_BIT] |-> irq)
		else $error("interrupt not raised");

	a_bad_addr: assert property (
		done && !mapped |-> pslverr && pready)
		else $error("unmapped access not flagged");

	a_read_clears: assert property ( // RL11
		done && hit_status && !pwrite && rd_status_r[DCC_CHANGE_BIT]
			&& !mismatch |=> !status_r[DCC_CHANGE_BIT])
		else $error("status read did not clear flag");

	a_flag_sticky: assert property ( // RL10
		status_r[DCC_CHANGE_BIT] && !(done && hit_status && !pwrite)
			|=> status_r[DCC_CHANGE_BIT])
		else $error("change flag dropped without read");

	a_read_ctrl: assert property ( // RL4
		setup && hit_ctrl && !pwrite |=>
			prdata == {24'h00_0000, $past(ctrl_r)})
		else $error("control read data wrong");

	a_oe_mode: assert property ( // RL3
		ctrl_r[2:0] == DCC_MODE_OUTPUTS |=> port_a_bit3_oe && port_a_bit4_oe)
		else $error("result pins not driven in output mode");

	a_vref_only: assert property ( // RL12
		ctrl_r[2:0] != DCC_MODE_VREF |=> !route.vref_to_pos)
		else $error("reference applied outside mode 010");

	a_pin_follow: assert property ( // RL1
		route.out_route |=> port_a_bit3_out == $past(result_r[0])
			&& port_a_bit4_out == $past(result_r[1]))
		else $error("result pins do not follow results");

	c_change_irq: cover property (
		mismatch ##1 irq ##[1:20] (done && hit_status && !pwrite));

	c_vref_mode: cover property (
		route.vref_to_pos && route.cmp2_neg_pin2);

	c_out_route: cover property (
		port_a_bit3_oe && port_a_bit3_out);

	c_set_beats_clear: cover property (
		done && hit_status && !pwrite && mismatch);

	c_switch_mode: cover property (
		route.cmp1_neg_pin3 && !route.vref_to_pos);

endmodule : dcc_top
`default_nettype wire

/* testbench/dcc_analog_model.sv */
// behavioural model of the analog comparators and their input pins
`timescale 1ns/1ps
`default_nettype none
module dcc_analog_model
	import dcc_pkg::*;
(
	input  wire dcc_route_t route,    // mux steering from the block
	input  wire logic [7:0] lvl0,     // level on port_a_bit0
	input  wire logic [7:0] lvl1,     // level on port_a_bit1
	input  wire logic [7:0] lvl2,     // level on port_a_bit2
	input  wire logic [7:0] lvl3,     // level on port_a_bit3
	input  wire logic [7:0] vref,     // internal reference level
	output logic            cmp1_raw, // comparator 1 output
	output logic            cmp2_raw  // comparator 2 output
);
	logic [7:0] plus1, minus1, plus2, minus2;

	// ------------------------------------------------------------
	// input multiplexers
	// ------------------------------------------------------------
	assign plus1  = route.vref_to_pos ? vref : lvl1;
	assign plus2  = route.vref_to_pos ? vref : lvl3;
	assign minus1 = route.cmp1_neg_pin3 ? lvl3 : lvl0;
	assign minus2 = route.cmp2_neg_pin2 ? lvl2 : lvl1;

	// ------------------------------------------------------------
	// comparators, output low while powered down
	// ------------------------------------------------------------
	assign cmp1_raw = route.cmp1_enable && (plus1 > minus1);
	assign cmp2_raw = route.cmp2_enable && (plus2 > minus2);
endmodule : dcc_analog_model
`default_nettype wire

/* testbench/testbench.sv */
// self-checking bench for the dual comparator control block
`timescale 1ns/1ps
`default_nettype none
`define chk(got, exp) \
	begin \
		n_checks++; \
		if ((got) !== (exp)) \
		begin \
			miscompares++; \
			$display("[ERR] %0t got %0h exp %0h", $time, (got), (exp)); \
		end \
	end
module testbench
	import dcc_pkg::*;
;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0]  paddr, lvl0, lvl1, lvl2, lvl3, vref;
	logic [31:0] pwdata, prdata, rd;
	logic        cmp1_raw, cmp2_raw, b3_out, b3_oe, b4_out, b4_oe, irq, err;
	dcc_route_t  route;
	int          miscompares, n_checks;
	logic [7:0]  wv [5] = '{8'h0A, 8'h09, 8'h01, 8'h06, 8'h07};
	logic [5:0]  rv [5] = '{6'h3E, 6'h38, 6'h30, 6'h31, 6'h00};

	dcc_top uut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .cmp1_raw(cmp1_raw), .cmp2_raw(cmp2_raw),
		.route(route), .port_a_bit3_out(b3_out), .port_a_bit3_oe(b3_oe),
		.port_a_bit4_out(b4_out), .port_a_bit4_oe(b4_oe), .irq(irq));

	dcc_analog_model analog (.route(route), .lvl0(lvl0), .lvl1(lvl1),
		.lvl2(lvl2), .lvl3(lvl3), .vref(vref), .cmp1_raw(cmp1_raw),
		.cmp2_raw(cmp2_raw));

	// ------------------------------------------------------------
	// bus tasks
	// ------------------------------------------------------------
	task apb_xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
		begin
			@(posedge pclk);
			psel <= 1'b1;
			pwrite <= wr;
			paddr <= a;
			pwdata <= d;
			@(posedge pclk);
			penable <= 1'b1;
			// only the watchdog ends a wait for the answer
			do
				@(posedge pclk);
			while (pready !== 1'b1);
			rd = prdata;
			err = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask : apb_xfer

	task wr_reg(input logic [7:0] a, input logic [31:0] d);
		apb_xfer(1'b1, a, d);
	endtask : wr_reg

	task rd_chk(input logic [7:0] a, input logic [31:0] exp);
		apb_xfer(1'b0, a, 32'h0);
		`chk(rd, exp)
	endtask : rd_chk

	task summarize;
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : summarize

	// ------------------------------------------------------------
	// clock and watchdog
	// ------------------------------------------------------------
	initial
	begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end

	initial
	begin
		#20000;
		miscompares++;
		summarize;
	end

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial
	begin
		presetn = 1'b0;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{lvl0, lvl1, lvl2, lvl3, vref} = {8'h14, 8'h14, 8'h14, 8'h14, 8'h50};
		miscompares = 0;
		n_checks = 0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		rd_chk(DCC_CTRL_ADDR, 32'h07);
		rd_chk(DCC_STATUS_ADDR, 32'h00);
		`chk(route, DCC_ROUTE_RESET)
		wr_reg(DCC_CTRL_ADDR, 32'hCF);
		rd_chk(DCC_CTRL_ADDR, 32'h0F);
		for (int i = 0; i < 5; i++)
		begin
			wr_reg(DCC_CTRL_ADDR, {24'h0, wv[i]});
			repeat (2) @(posedge pclk);
			`chk(route, rv[i])
		end
		wr_reg(DCC_MASK_ADDR, 32'hFF);
		rd_chk(DCC_MASK_ADDR, 32'h01);
		`chk(err, 1'b0)
		wr_reg(DCC_CTRL_ADDR, 32'h32);
		repeat (6) @(posedge pclk);
		rd_chk(DCC_CTRL_ADDR, 32'h32);
		wr_reg(DCC_CTRL_ADDR, 32'h02);
		repeat (6) @(posedge pclk);
		rd_chk(DCC_CTRL_ADDR, 32'hC2);
		apb_xfer(1'b0, DCC_STATUS_ADDR, 32'h0);
		rd_chk(DCC_STATUS_ADDR, 32'h00);
		`chk(irq, 1'b0)
		lvl0 <= 8'hC8;
		repeat (6) @(posedge pclk);
		`chk(irq, 1'b1)
		rd_chk(DCC_STATUS_ADDR, 32'h01);
		rd_chk(DCC_STATUS_ADDR, 32'h01);
		rd_chk(DCC_CTRL_ADDR, 32'h82);
		rd_chk(DCC_STATUS_ADDR, 32'h01);
		rd_chk(DCC_STATUS_ADDR, 32'h00);
		`chk(irq, 1'b0)
		wr_reg(DCC_CTRL_ADDR, 32'h0A);
		repeat (6) @(posedge pclk);
		rd_chk(DCC_CTRL_ADDR, 32'hCA);
		{lvl0, lvl1, lvl3} <= {8'h14, 8'h64, 8'hC8};
		wr_reg(DCC_CTRL_ADDR, 32'h06);
		repeat (6) @(posedge pclk);
		`chk({b3_out, b3_oe, b4_out, b4_oe}, 4'hF)
		lvl1 <= 8'hFA;
		repeat (6) @(posedge pclk);
		`chk({b3_out, b3_oe, b4_out, b4_oe}, 4'hD)
		apb_xfer(1'b0, 8'h10, 32'h0);
		`chk(err, 1'b1)
		`chk(rd, 32'h0)
		presetn <= 1'b0;
		@(posedge pclk);
		presetn <= 1'b1;
		rd_chk(DCC_CTRL_ADDR, 32'h07);
		summarize;
	end
endmodule : testbench
`default_nettype wire
